// *** tbs_pkg.sv ***
package tbs_pkg;

  // ----------------------------------------------------------------
  // Write control cycle
  // ----------------------------------------------------------------
  localparam int unsigned TBS_CYCLE_CLOCKS = 10;
  localparam int unsigned TBS_HIGH_CLOCKS = 8;
  localparam int unsigned TBS_GAP_CLOCKS = 2;
  localparam logic [7:0] TBS_BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing on the core clock
  // ----------------------------------------------------------------
  localparam int unsigned TBS_CORE_CLK_KHZ = 50000;
  localparam int unsigned TBS_TIMER_US = 40;
  localparam int unsigned TBS_TIMER_CYCLES = TBS_TIMER_US * TBS_CORE_CLK_KHZ / 1000;
  localparam int unsigned TBS_DEBOUNCE_US = 20;
  localparam int unsigned TBS_DEBOUNCE_CYCLES = TBS_DEBOUNCE_US * TBS_CORE_CLK_KHZ / 1000;
  localparam int unsigned TBS_CNT_W = 11;

  // ----------------------------------------------------------------
  // Write sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TBS_IDLE = 2'b00,
    TBS_CLEAR = 2'b01,
    TBS_RUN = 2'b10
  } tbs_wstate_e;

endpackage : tbs_pkg

// *** tbs_debounce.sv ***
`timescale 1ns/10ps

module tbs_debounce
  import tbs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Raw and cleaned level
  input wire logic raw_in,
  output logic clean_out
);

  logic [1:0] sync_r;
  logic [TBS_CNT_W-1:0] cnt_r;
  logic [TBS_CNT_W-1:0] cnt_nxt;
  logic clean_r;
  logic clean_nxt;

  // Two-stage synchroniser; only the second stage is read by the filter.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync_r <= 2'b00;
    end else begin
      sync_r <= {sync_r[0], raw_in};
    end
  end

  // The output only follows once the input held steady for the full delay.
  always_comb begin
    cnt_nxt = '0;
    clean_nxt = clean_r;
    if (sync_r[1] != clean_r) begin
      if (cnt_r == TBS_CNT_W'(TBS_DEBOUNCE_CYCLES - 1)) begin
        clean_nxt = sync_r[1];
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      clean_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clean_r <= clean_nxt;
    end
  end

  assign clean_out = clean_r;

endmodule : tbs_debounce

// *** tbs_serializer.sv ***
`timescale 1ns/10ps

// Summary of operation
// - Write byte loads in parallel, then shifts out serially as write data.
// - Read path shifts serial read data in, presents eight parallel bits.
// - Waveform repeats eight high, two low while writing; low otherwise.
// - Idle: waveform low, strobe and write shifter receive no clocks.
// - Gate enable rises: first clock clears shifter, second raises waveform.
// - Tenth clock: one reaches tail bit, clears waveform, rearms cycle.
// - First two clocks of a cycle suppress the strobe, giving the gap.
// - Waveform fall puts the write shifter into parallel load mode.
// - Waveform fall raises the byte-sent interrupt line to the host.
// - Gate enable drop finishes the current cycle, then returns idle.
// - Separate shifter inputs: read data into the read shifter, waveform into the write control shifter.
// - Separate shifter clocks: read strobe for the read shifter, bit clock for write control.
// - Bit clocks reach write shifter and strobe only while waveform high.
// - Mark generation holds serial write data low.
// - Strobe pulses on write shifts, or on timer trigger during marks.
// - Timer trigger is isolated from the strobe outside mark generation.
// - Timer trigger rests high; read-port read pulses it; 40 us one-shot.
// - Cartridge switch grounding sets latch; absent flag on panel bit 6.
// - Toggling aux A output bit 1 clears the cartridge-absent latch.
// - Tape-logic initialize is high on reset or while the absent latch is set.
// - Begin/end markers debounced about 20 us, then drive B-side lines.
module tbs_serializer
  import tbs_pkg::*;
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Link clocks
  input wire logic bit_rate_clock,
  input wire logic read_strobe,
  // Host write side
  input wire logic [7:0] write_data_port,
  input wire logic write_gate_enable,
  input wire logic mark_generation,
  input wire logic read_mode,
  output logic b_side_control_line1,
  // Host read side
  output logic [7:0] read_data_port,
  input wire logic read_port_access,
  output logic timer_trigger_line,
  output logic aux_a_bit0,
  // Head board
  input wire logic read_data,
  output logic write_data,
  output logic write_strobe,
  output logic write_waveform,
  // Cartridge and markers
  input wire logic cartridge_switch_n,
  input wire logic aux_a_bit1,
  output logic panel_bit6,
  output logic tape_init,
  input wire logic tape_begin_marker,
  input wire logic tape_end_marker,
  output logic aux_b_control_line1,
  output logic aux_b_control_line2
);

  // ----------------------------------------------------------------
  // Bit clock domain: synchronisers
  // ----------------------------------------------------------------
  logic [1:0] wen_sync_r;
  logic [1:0] mark_sync_r;
  logic [1:0] rdm_w_sync_r;

  // Host levels cross into the bit clock domain via two flops each.
  always_ff @(posedge bit_rate_clock or negedge nrst) begin
    if (!nrst) begin
      wen_sync_r <= 2'b00;
      mark_sync_r <= 2'b00;
      rdm_w_sync_r <= 2'b00;
    end else begin
      wen_sync_r <= {wen_sync_r[0], write_gate_enable};
      mark_sync_r <= {mark_sync_r[0], mark_generation};
      rdm_w_sync_r <= {rdm_w_sync_r[0], read_mode};
    end
  end

  logic wen_s;
  logic mark_s;
  logic writing_s;
  assign wen_s = wen_sync_r[1];
  assign mark_s = mark_sync_r[1];
  assign writing_s = !rdm_w_sync_r[1];

  // ----------------------------------------------------------------
  // Bit clock domain: write control sequencer
  // ----------------------------------------------------------------
  // The write control register is preloaded with a one at its tail; after clearing,
  // a one is fed in at the head so it arrives at the tail on the tenth clock.
  tbs_wstate_e wstate_r;
  tbs_wstate_e wstate_nxt;
  logic [7:0] wshift_r;
  logic [7:0] wshift_nxt;
  logic [7:0] wload_r;
  logic [7:0] wload_nxt;
  logic [7:0] rw_shift_r;
  logic [7:0] rw_shift_nxt;
  logic wave_r;
  logic wave_nxt;
  logic gap_r;
  logic gap_nxt;
  logic wdata_r;
  logic wdata_nxt;
  logic wstrobe_en_r;
  logic wstrobe_en_nxt;

  always_comb begin
    wstate_nxt = wstate_r;
    wshift_nxt = wshift_r;
    rw_shift_nxt = rw_shift_r;
    wave_nxt = wave_r;
    gap_nxt = gap_r;
    wdata_nxt = wdata_r;
    wstrobe_en_nxt = 1'b0;
    wload_nxt = wload_r;
    case (wstate_r)
      TBS_IDLE: begin
        wave_nxt = 1'b0;
        rw_shift_nxt = 8'h80;
        if (wen_s && writing_s) begin
          // First gap clock of every cycle, including back-to-back bytes.
          wstate_nxt = TBS_CLEAR;
          rw_shift_nxt = TBS_BYTE_RESET;
          wload_nxt = write_data_port;
          gap_nxt = 1'b1;
        end
      end
      TBS_CLEAR: begin
        // Second gap clock: register released and waveform goes high.
        wave_nxt = 1'b1;
        gap_nxt = 1'b0;
        wshift_nxt = wload_r;
        rw_shift_nxt = {rw_shift_r[6:0], 1'b1};
        wstate_nxt = TBS_RUN;
      end
      TBS_RUN: begin
        // Data shifts out only while the waveform is high.
        wdata_nxt = wshift_r[7] & !mark_s;
        wshift_nxt = {wshift_r[6:0], 1'b0};
        wstrobe_en_nxt = 1'b1;
        rw_shift_nxt = {rw_shift_r[6:0], wave_r};
        if (rw_shift_r[7]) begin
          // Tail bit reached: waveform falls and shifter returns to load.
          wave_nxt = 1'b0;
          wstrobe_en_nxt = 1'b0;
          wshift_nxt = write_data_port;
          wload_nxt = write_data_port;
          // Always pass through idle so the gap spans two full bit clocks;
          // idle restarts at once while the gate enable is still high.
          wstate_nxt = TBS_IDLE;
        end
      end
      default: begin
        wstate_nxt = TBS_IDLE;
        wave_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge bit_rate_clock or negedge nrst) begin
    if (!nrst) begin
      wstate_r <= TBS_IDLE;
      wshift_r <= TBS_BYTE_RESET;
      wload_r <= TBS_BYTE_RESET;
      rw_shift_r <= 8'h80;
      wave_r <= 1'b0;
      gap_r <= 1'b0;
      wdata_r <= 1'b0;
      wstrobe_en_r <= 1'b0;
    end else begin
      wstate_r <= wstate_nxt;
      wshift_r <= wshift_nxt;
      wload_r <= wload_nxt;
      rw_shift_r <= rw_shift_nxt;
      wave_r <= wave_nxt;
      gap_r <= gap_nxt;
      wdata_r <= wdata_nxt;
      wstrobe_en_r <= wstrobe_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read strobe domain: serial to parallel
  // ----------------------------------------------------------------
  logic [7:0] rd_shift_r;
  logic [7:0] rd_shift_nxt;
  logic [2:0] rd_cnt_r;
  logic [2:0] rd_cnt_nxt;
  logic [7:0] rd_byte_r;
  logic [7:0] rd_byte_nxt;
  logic rd_tog_r;
  logic rd_tog_nxt;

  // The read strobe stops between bytes, so a completed byte is held and
  // announced by a toggle that the core domain picks up on its own clock.
  always_comb begin
    rd_shift_nxt = {rd_shift_r[6:0], read_data};
    rd_cnt_nxt = rd_cnt_r + 3'd1;
    rd_byte_nxt = rd_byte_r;
    rd_tog_nxt = rd_tog_r;
    if (rd_cnt_r == 3'd7) begin
      rd_byte_nxt = {rd_shift_r[6:0], read_data};
      rd_tog_nxt = !rd_tog_r;
    end
  end

  always_ff @(posedge read_strobe or negedge nrst) begin
    if (!nrst) begin
      rd_shift_r <= TBS_BYTE_RESET;
      rd_cnt_r <= 3'd0;
      rd_byte_r <= TBS_BYTE_RESET;
      rd_tog_r <= 1'b0;
    end else begin
      rd_shift_r <= rd_shift_nxt;
      rd_cnt_r <= rd_cnt_nxt;
      rd_byte_r <= rd_byte_nxt;
      rd_tog_r <= rd_tog_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: crossings from the link clocks and the asynchronous inputs
  // ----------------------------------------------------------------
  logic [2:0] rtog_sync_r;
  logic [2:0] wave_sync_r;
  logic [1:0] marksc_sync_r;
  logic [1:0] switch_sync_r;
  logic [1:0] bit1_sync_r;
  logic [1:0] access_sync_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rtog_sync_r <= 3'b000;
      wave_sync_r <= 3'b000;
      marksc_sync_r <= 2'b00;
      switch_sync_r <= 2'b11;
      bit1_sync_r <= 2'b00;
      access_sync_r <= 2'b00;
    end else begin
      rtog_sync_r <= {rtog_sync_r[1:0], rd_tog_r};
      wave_sync_r <= {wave_sync_r[1:0], wave_r};
      marksc_sync_r <= {marksc_sync_r[0], mark_generation};
      switch_sync_r <= {switch_sync_r[0], cartridge_switch_n};
      bit1_sync_r <= {bit1_sync_r[0], aux_a_bit1};
      access_sync_r <= {access_sync_r[0], read_port_access};
    end
  end

  // ----------------------------------------------------------------
  // Core domain: host side registers, timer and cartridge latch
  // ----------------------------------------------------------------
  logic [7:0] rd_port_r;
  logic [7:0] rd_port_nxt;
  logic cb1_r;
  logic cb1_nxt;
  logic bit1_prev_r;
  logic access_prev_r;
  logic trig_n_r;
  logic trig_n_nxt;
  logic [TBS_CNT_W-1:0] timer_r;
  logic [TBS_CNT_W-1:0] timer_nxt;
  logic cartridge_absent_r;
  logic cartridge_absent_nxt;

  always_comb begin
    rd_port_nxt = rd_port_r;
    if (rtog_sync_r[2] != rtog_sync_r[1]) begin
      rd_port_nxt = rd_byte_r;
    end
    // Falling waveform flags the host that the next byte may be loaded.
    cb1_nxt = wave_sync_r[2] && !wave_sync_r[1];
    // Trigger rests high and dips for one cycle on each read-port access.
    trig_n_nxt = !(access_sync_r[1] && !access_prev_r);
    timer_nxt = timer_r;
    if (!trig_n_r) begin
      timer_nxt = TBS_CNT_W'(TBS_TIMER_CYCLES);
    end else if (timer_r != '0) begin
      timer_nxt = timer_r - 1'b1;
    end
    // Set dominates so a removal is never lost under a clear.
    cartridge_absent_nxt = cartridge_absent_r;
    if (bit1_sync_r[1] != bit1_prev_r) begin
      cartridge_absent_nxt = 1'b0;
    end
    if (!switch_sync_r[1]) begin
      cartridge_absent_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_port_r <= TBS_BYTE_RESET;
      cb1_r <= 1'b0;
      bit1_prev_r <= 1'b0;
      access_prev_r <= 1'b0;
      trig_n_r <= 1'b1;
      timer_r <= '0;
      cartridge_absent_r <= 1'b0;
    end else begin
      rd_port_r <= rd_port_nxt;
      cb1_r <= cb1_nxt;
      bit1_prev_r <= bit1_sync_r[1];
      access_prev_r <= access_sync_r[1];
      trig_n_r <= trig_n_nxt;
      timer_r <= timer_nxt;
      cartridge_absent_r <= cartridge_absent_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Marker debouncers
  // ----------------------------------------------------------------
  tbs_debounce u_begin (
    .core_clk(core_clk),
    .nrst(nrst),
    .raw_in(tape_begin_marker),
    .clean_out(aux_b_control_line1)
  );

  tbs_debounce u_end (
    .core_clk(core_clk),
    .nrst(nrst),
    .raw_in(tape_end_marker),
    .clean_out(aux_b_control_line2)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The strobe is gated from the bit clock itself so each pulse lines up
  // with a shift; the timer trigger only reaches it during mark writing.
  assign write_strobe = (wstrobe_en_r & bit_rate_clock)
                      | (marksc_sync_r[1] & !trig_n_r);
  assign write_data = wdata_r & !mark_s;
  assign write_waveform = wave_r;
  assign b_side_control_line1 = cb1_r;
  assign read_data_port = rd_port_r;
  assign timer_trigger_line = trig_n_r;
  assign aux_a_bit0 = timer_r != '0;
  assign panel_bit6 = cartridge_absent_r;
  assign tape_init = !nrst | cartridge_absent_r;

endmodule : tbs_serializer

// *** tbs_serializer_chk.sv ***
`timescale 1ns/10ps

module tbs_serializer_chk
  import tbs_pkg::*;
(
  // Clocks and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic bit_rate_clock,
  // Write side
  input wire logic mark_generation,
  input wire logic write_waveform,
  input wire logic write_strobe,
  input wire logic write_data,
  input wire logic b_side_control_line1,
  // Timer
  input wire logic read_port_access,
  input wire logic timer_trigger_line,
  input wire logic aux_a_bit0,
  // Cartridge and markers
  input wire logic cartridge_switch_n,
  input wire logic aux_a_bit1,
  input wire logic panel_bit6,
  input wire logic tape_init,
  input wire logic tape_begin_marker,
  input wire logic aux_b_control_line1
);
  logic [11:0] hi_cnt_r, hi_cnt_nxt, beg_cnt_r, beg_cnt_nxt;

  // High-run lengths; 12 bits is enough only because no run lasts past 4095 cycles.
  always_comb begin
    hi_cnt_nxt = aux_a_bit0 ? hi_cnt_r + 12'h001 : 12'h000;
    beg_cnt_nxt = tape_begin_marker ? beg_cnt_r + 12'h001 : 12'h000;
  end

  // Registers for the run lengths.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_r <= 12'h000;
      beg_cnt_r <= 12'h000;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      beg_cnt_r <= beg_cnt_nxt;
    end
  end

  // Waveform shape and mark data seen at the bit clock.
  property p_wave_shape;
    @(posedge bit_rate_clock) disable iff (!nrst)
      $rose(write_waveform) |-> write_waveform[*8] ##1 !write_waveform;
  endproperty
  a_wave_shape: assert property (p_wave_shape) else $error("waveform high run wrong");
  property p_wave_gap;
    @(posedge bit_rate_clock) disable iff (!nrst) $fell(write_waveform) |-> ##1 !write_waveform;
  endproperty
  a_wave_gap: assert property (p_wave_gap) else $error("gap shorter than two clocks");
  property p_data_mark;
    @(posedge bit_rate_clock) disable iff (!nrst) mark_generation[*3] |-> !write_data;
  endproperty
  a_data_mark: assert property (p_data_mark) else $error("write data high during marks");

  // Strobe gating, byte-sent pulse and timer.
  property p_strobe_gate;
    @(posedge core_clk) disable iff (!nrst)
      (!write_waveform && !mark_generation) |-> !write_strobe;
  endproperty
  a_strobe_gate: assert property (p_strobe_gate) else $error("strobe while gated off");
  property p_sent_pulse;
    @(posedge core_clk) disable iff (!nrst)
      $fell(write_waveform) |-> ##[1:8] b_side_control_line1;
  endproperty
  a_sent_pulse: assert property (p_sent_pulse) else $error("no byte-sent pulse");
  property p_trig_low;
    @(posedge core_clk) disable iff (!nrst)
      $rose(read_port_access) |-> ##[1:5] !timer_trigger_line ##1 timer_trigger_line;
  endproperty
  a_trig_low: assert property (p_trig_low) else $error("trigger pulse wrong");
  property p_oneshot_len;
    @(posedge core_clk) disable iff (!nrst)
      $fell(aux_a_bit0) |-> (hi_cnt_r + 4 >= TBS_TIMER_CYCLES && hi_cnt_r <= TBS_TIMER_CYCLES + 4);
  endproperty
  a_oneshot_len: assert property (p_oneshot_len) else $error("one-shot length wrong");

  // Cartridge latch and marker debounce.
  property p_cart_set;
    @(posedge core_clk) disable iff (!nrst)
      $fell(cartridge_switch_n) |-> ##[1:6] (panel_bit6 && tape_init);
  endproperty
  a_cart_set: assert property (p_cart_set) else $error("absent latch not set");
  property p_cart_clear;
    @(posedge core_clk) disable iff (!nrst)
      (cartridge_switch_n[*4] ##0 $changed(aux_a_bit1)) |-> ##[1:6] !panel_bit6;
  endproperty
  a_cart_clear: assert property (p_cart_clear) else $error("absent latch not cleared");
  property p_begin_delay;
    @(posedge core_clk) disable iff (!nrst)
      $rose(aux_b_control_line1) |-> (beg_cnt_r + 2 >= TBS_DEBOUNCE_CYCLES && beg_cnt_r <= TBS_DEBOUNCE_CYCLES + 8);
  endproperty
  a_begin_delay: assert property (p_begin_delay) else $error("begin marker delay wrong");

  // Main scenarios reached.
  c_byte_end: cover property (@(posedge core_clk) $fell(write_waveform));
  c_timer_end: cover property (@(posedge core_clk) $fell(aux_a_bit0));
  c_begin_set: cover property (@(posedge core_clk) $rose(aux_b_control_line1));
endmodule : tbs_serializer_chk

bind tbs_serializer tbs_serializer_chk u_chk (.*);

// *** tbs_head_model.sv ***
`timescale 1ns/10ps

module tbs_head_model (
  // Bench control
  input wire logic run_clk,
  // Head board pins
  input wire logic write_data,
  output logic bit_rate_clock,
  output logic read_strobe,
  output logic read_data,
  // Recent written bits, newest in bit 0
  output logic [7:0] hist
);
  // Bit clock runs only on request; the 7 ns offset keeps its edges off the core clock.
  initial begin
    bit_rate_clock = 1'h0;
    read_strobe = 1'h0;
    read_data = 1'h0;
    #7;
    forever begin
      #40;
      bit_rate_clock = run_clk ? ~bit_rate_clock : 1'h0;
    end
  end

  // Written data is taken half a bit after the launching edge.
  always @(negedge bit_rate_clock) hist <= {hist[6:0], write_data};

  // Sends n bits first-bit-high, then leaves the line at the inverse of the last bit.
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      read_data = b[i];
      #20 read_strobe = 1'h1;
      #20 read_strobe = 1'h0;
    end
    read_data = ~read_data;
  endtask : send_bits
endmodule : tbs_head_model

// *** tape_byte_serializer_control_test.sv ***
`timescale 1ns/10ps

module tape_byte_serializer_control_test;
  logic core_clk = 1'h0, nrst = 1'h0, run_clk = 1'h1, seen;
  logic bit_rate_clock, read_strobe, read_data, write_data, write_strobe, write_waveform;
  logic [7:0] write_data_port = 8'hA5, read_data_port, hist;
  logic write_gate_enable = 1'h0, mark_generation = 1'h0, read_mode = 1'h0;
  logic read_port_access = 1'h0, b_side_control_line1, timer_trigger_line, aux_a_bit0;
  logic cartridge_switch_n = 1'h1, aux_a_bit1 = 1'h0, panel_bit6, tape_init;
  logic tape_begin_marker = 1'h0, tape_end_marker = 1'h0;
  logic aux_b_control_line1, aux_b_control_line2;
  logic [7:0] wbytes [3] = '{8'hA5, 8'h3C, 8'h81};
  int n_errors = 0, n_tests = 0, cyc = 0, n_sent = 0;

  tbs_serializer DUT (.*);
  tbs_head_model head (.*);

  always #10 core_clk = ~core_clk;

  // Cycle limit and byte-sent pulse count.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (b_side_control_line1 === 1'h1) n_sent <= n_sent + 1;
    if (cyc == 15000) begin
      n_errors = n_errors + 1;
      $display("[FAIL] run length expected under 15000 seen 15000");
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Bounded wait for a waveform level, which is then compared.
  task automatic wait_wave(input logic lvl);
    for (int k = 0; k < 200 && write_waveform !== lvl; k++) @(posedge core_clk);
    check("waveform", {7'h00, lvl}, {7'h00, write_waveform});
  endtask : wait_wave

  // Host read of the read port; watches the strobe, then polls the one-shot until it ends.
  task automatic access_watch(output logic s);
    s = 1'h0;
    read_port_access <= 1'h1;
    tick(2);
    read_port_access <= 1'h0;
    repeat (12) begin
      @(posedge core_clk);
      #1 if (write_strobe === 1'h1) s = 1'h1;
    end
    check("one-shot", 8'h01, {7'h00, aux_a_bit0});
    while (aux_a_bit0 !== 1'h0) tick(1);
  endtask : access_watch

  initial begin
    head.send_bits(8'h00, 2);
    check("reset trigger", 8'h01, {7'h00, timer_trigger_line});
    check("reset init", 8'h01, {7'h00, tape_init});
    check("reset waveform", 8'h00, {7'h00, write_waveform});
    tick(2);
    nrst <= 1'h1;
    tick(3);
    check("init released", 8'h00, {7'h00, tape_init});
    // Three bytes back to back; the gate drops during the last one.
    write_gate_enable <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      wait_wave(1'h1);
      write_data_port <= wbytes[(i + 1) % 3];
      if (i == 2) write_gate_enable <= 1'h0;
      wait_wave(1'h0);
      @(negedge bit_rate_clock);
      #1 check("written byte", wbytes[i], hist);
      @(posedge core_clk);
    end
    tick(60);
    check("idle after stop", 8'h00, {7'h00, write_waveform});
    check("sent pulses", 8'h03, 8'(n_sent));
    // Timer use with and without mark generation.
    access_watch(seen);
    check("strobe isolated", 8'h00, {7'h00, seen});
    mark_generation <= 1'h1;
    tick(30);
    access_watch(seen);
    check("mark strobe", 8'h01, {7'h00, seen});
    check("mark data", 8'h00, {7'h00, write_data});
    mark_generation <= 1'h0;
    run_clk <= 1'h0;
    read_mode <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      head.send_bits(wbytes[i], 8);
      tick(8);
      check("read byte", wbytes[i], read_data_port);
    end
    read_mode <= 1'h0;
    cartridge_switch_n <= 1'h0;
    tick(5);
    cartridge_switch_n <= 1'h1;
    tick(5);
    check("absent flag", 8'h01, {7'h00, panel_bit6});
    check("init on removal", 8'h01, {7'h00, tape_init});
    aux_a_bit1 <= ~aux_a_bit1;
    tick(8);
    check("absent cleared", 8'h00, {7'h00, panel_bit6});
    // A short end-marker bounce is ignored; steady markers pass after the delay.
    tape_end_marker <= 1'h1;
    tick(300);
    tape_end_marker <= 1'h0;
    tick(50);
    check("bounce ignored", 8'h00, {7'h00, aux_b_control_line2});
    tape_begin_marker <= 1'h1;
    tape_end_marker <= 1'h1;
    tick(900);
    check("begin early", 8'h00, {7'h00, aux_b_control_line1});
    tick(200);
    check("begin late", 8'h01, {7'h00, aux_b_control_line1});
    check("end late", 8'h01, {7'h00, aux_b_control_line2});
    close_out();
  end
endmodule : tape_byte_serializer_control_test
